//--- verilog/tec_pkg.sv
// shared constants for the thermometer/eeprom command engine and its master
`default_nettype none
package tec_pkg;
  // ---------------------------------------------------------------
  // link protocol codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_CODE     = 4'h9;  // control byte upper nibble
  localparam logic [7:0] CMD_READ_TEMP = 8'haa;
  localparam logic [7:0] CMD_CONV_GO   = 8'hee;
  localparam logic [7:0] CMD_CONV_HALT = 8'h22;
  localparam logic [7:0] CMD_MEM       = 8'h17;
  localparam logic [7:0] CMD_CFG       = 8'hac;
  localparam logic [7:0] IDLE_BYTE     = 8'hff;  // read filler
  // ---------------------------------------------------------------
  // conversion_settings_status layout
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_FIXED     = 8'h0a;  // bits 6..1 constant
  localparam int         CFG_DONE_BIT  = 7;
  localparam int         CFG_SHOT_BIT  = 0;
  localparam logic       SHOT_RESET    = 1'b0;   // continuous conversion
  localparam logic [3:0] TEMP_LOW_ZERO = 4'h0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned T_PROG_US       = 10000;  // nonvolatile commit
  localparam int unsigned PROG_CYCLES_DEF = T_PROG_US * CLK_MHZ;
  localparam int unsigned CONV_CYCLES_DEF = 3000;   // plain default
  localparam int unsigned TICK_DIV        = 4;      // clocks per quarter bit
  // ---------------------------------------------------------------
  // master register map
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_CMD    = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam int         OP_LSB     = 8;   // [9:8] operation
  localparam int         ACKOUT_BIT = 10;  // ack to send after a read
  localparam int         BUSY_BIT   = 0;
  localparam int         ACKIN_BIT  = 1;
  localparam int         RDATA_LSB  = 8;
  localparam logic [1:0] OP_START   = 2'h0;
  localparam logic [1:0] OP_STOP    = 2'h1;
  localparam logic [1:0] OP_WRITE   = 2'h2;
  localparam logic [1:0] OP_READ    = 2'h3;
  localparam logic [1:0] RESP_OK    = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;
endpackage
`default_nettype wire

//--- verilog/tec_link_if.sv
// two-wire link between the command engine and its bus master
`default_nettype none
interface tec_link_if;
  logic scl_o;      // master clock drive value
  logic scl_oe;     // master drives scl
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;        // resolved line levels, pulled up
  logic sda;
  // open drain: an undriven line floats high
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);
  modport device (input scl, sda, output d_sda_o, d_sda_oe);
  modport master (input scl, sda, output scl_o, scl_oe, m_sda_o, m_sda_oe);
endinterface
`default_nettype wire

//--- verilog/tec_device.sv
// command engine of the two-wire thermometer with nonvolatile memory
// Notes on behaviour
// - done flag: 1 finished, 0 converting
// - single select 1: one conversion, else repeat
// - single select kept nonvolatile, delivered as 0 (here nrst reloads it with SHOT_RESET)
// - config write commits after 10ms; master waits
// - 17h, address, data, then STOP programs
// - repeated START instead of STOP aborts write
// - no acknowledge while programming, done within 50ms
// - page data acked, staged in 8 bytes
// - page writes advance only low 3 pointer bits
// - STOP after first data byte programs one byte
// - memory read: set pointer, restart, read on
// - read pointer wraps FFh to 00h
// - AAh then read returns two temperature bytes
// - EEh starts conversion, once or continuously
// - 22h finishes current conversion then idles
// - ACh writes or reads the settings byte
// - command byte acked; reads need restart
// - master waits 10ms after nonvolatile writes
// - answer only control 1001 with matching unit
// - temperature 16-bit, MSB first, low nibble zero
// - settings byte: done bit 7, select bit 0
//
// Added by the designer: the address map and the AXI4-Lite register port.
`default_nettype none
module tec_device #(
  parameter int unsigned PROG_CYCLES = tec_pkg::PROG_CYCLES_DEF,
  parameter int unsigned CONV_CYCLES = tec_pkg::CONV_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // two-wire link
  tec_link_if.device       link,
  // sensor side
  input  wire logic [2:0]  unit_select,
  input  wire logic [15:0] temp_in,
  // status
  output var  logic        prog_busy,
  output var  logic        converting
);
  import tec_pkg::*;

  typedef enum logic [4:0] {
    TEC_IDLE = 5'b00001,
    TEC_CTRL = 5'b00010,
    TEC_CMD  = 5'b00100,
    TEC_DATA = 5'b01000,
    TEC_READ = 5'b10000
  } tec_state_t;

  tec_state_t  state;
  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic        scl_q;
  logic        sda_q;
  logic        scl_s;
  logic        sda_s;
  logic [2:0]  unit_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic [3:0]  cnt;
  logic [7:0]  rx;
  logic [7:0]  tx;
  logic [7:0]  cmd;
  logic [7:0]  ptr;
  logic [1:0]  rd_idx;
  logic        data_first;
  logic        master_ack;
  logic [7:0]  stage [8];
  logic [7:0]  mask;
  logic        mem_pend;
  logic        cfg_pend;
  logic        cfg_val;
  logic        prog_go;
  logic        conv_go;
  logic        conv_halt;
  logic [31:0] prog_cnt;
  logic [7:0]  commit_mask;
  logic [4:0]  commit_base;
  logic        commit_cfg;
  logic        commit_cfg_val;
  logic        commit_now;
  logic [7:0]  mem [256];
  logic        one_shot;
  logic        run;
  logic        done;
  logic [31:0] conv_cnt;
  logic [15:0] temp;
  logic [7:0]  cfg_byte;
  logic [7:0]  next_tx;

  // --------------
  // link sampling
  // --------------
  // pins and straps pass two flops; only sync2 feeds logic
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      sync1 <= {unit_select, link.sda, link.scl};
      sync2 <= sync1;
      scl_q <= sync2[0];
      sda_q <= sync2[1];
    end
  end

  // edge and bus condition decode
  assign scl_s    = sync2[0];
  assign sda_s    = sync2[1];
  assign unit_s   = sync2[4:2];
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

  // open drain: we only ever pull low
  assign link.d_sda_o = 1'b0;

  // -----------------
  // read data source
  // -----------------
  // fixed bits stay constant, live flag and select ride along
  always_comb begin
    cfg_byte               = CFG_FIXED;
    cfg_byte[CFG_DONE_BIT] = done;
    cfg_byte[CFG_SHOT_BIT] = one_shot;
  end

  // byte offered for the next read slot, chosen by the last command
  always_comb begin
    next_tx = IDLE_BYTE;
    case (cmd)
      CMD_READ_TEMP: begin
        if (rd_idx == 2'd0) begin
          next_tx = temp[15:8];
        end else if (rd_idx == 2'd1) begin
          next_tx = temp[7:0];
        end
      end
      CMD_CFG: next_tx = cfg_byte;
      CMD_MEM: next_tx = mem[ptr];
      default: next_tx = IDLE_BYTE;
    endcase
  end

  // --------------
  // byte protocol
  // --------------
  // bit count runs 0..9 on rises; falls drive data and acknowledge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state           <= TEC_IDLE;
      cnt             <= 4'h0;
      rx              <= 8'h00;
      tx              <= 8'h00;
      cmd             <= 8'h00;
      ptr             <= 8'h00;
      rd_idx          <= 2'h0;
      data_first      <= 1'b0;
      master_ack      <= 1'b0;
      mask            <= 8'h00;
      mem_pend        <= 1'b0;
      cfg_pend        <= 1'b0;
      cfg_val         <= 1'b0;
      prog_go         <= 1'b0;
      conv_go         <= 1'b0;
      conv_halt       <= 1'b0;
      link.d_sda_oe   <= 1'b0;
    end else begin
      prog_go   <= 1'b0;
      conv_go   <= 1'b0;
      conv_halt <= 1'b0;
      if (start_ev) begin
        // a restart drops any staged write
        state         <= TEC_CTRL;
        cnt           <= 4'h0;
        link.d_sda_oe <= 1'b0;
        mem_pend      <= 1'b0;
        cfg_pend      <= 1'b0;
      end else if (stop_ev) begin
        state         <= TEC_IDLE;
        link.d_sda_oe <= 1'b0;
        prog_go       <= mem_pend | cfg_pend;
      end else if (state != TEC_IDLE) begin
        if (scl_rise) begin
          if (cnt < 4'd8) begin
            rx <= {rx[6:0], sda_s};
          end else begin
            master_ack <= ~sda_s;
          end
          cnt <= cnt + 4'd1;
        end else if (scl_fall) begin
          if (cnt == 4'd8) begin
            case (state)
              TEC_CTRL: begin
                if (rx[7:4] == CTRL_CODE && rx[3:1] == unit_s
                    && !prog_busy) begin
                  link.d_sda_oe <= 1'b1;
                  state         <= rx[0] ? TEC_READ : TEC_CMD;
                  rd_idx        <= 2'h0;
                end else begin
                  state <= TEC_IDLE;
                end
              end
              TEC_CMD: begin
                link.d_sda_oe <= 1'b1;
                cmd           <= rx;
                state         <= TEC_DATA;
                data_first    <= 1'b1;
                conv_go       <= (rx == CMD_CONV_GO);
                conv_halt     <= (rx == CMD_CONV_HALT);
              end
              TEC_DATA: begin
                link.d_sda_oe <= 1'b1;
                data_first    <= 1'b0;
                if (cmd == CMD_MEM) begin
                  if (data_first) begin
                    ptr  <= rx;
                    mask <= 8'h00;
                  end else begin
                    mask[ptr[2:0]] <= 1'b1;
                    ptr[2:0]       <= ptr[2:0] + 3'd1;
                    mem_pend       <= 1'b1;
                  end
                end else if (cmd == CMD_CFG && data_first) begin
                  cfg_val  <= rx[CFG_SHOT_BIT];
                  cfg_pend <= 1'b1;
                end
              end
              default: link.d_sda_oe <= 1'b0;  // let master ack
            endcase
          end else if (cnt == 4'd9) begin
            cnt           <= 4'h0;
            link.d_sda_oe <= 1'b0;
            if (state == TEC_READ) begin
              // ack sampled on the ninth rise gates the next byte
              if (master_ack) begin
                tx            <= next_tx;
                link.d_sda_oe <= ~next_tx[7];
                if (rd_idx != 2'h3) begin
                  rd_idx <= rd_idx + 2'h1;
                end
                if (cmd == CMD_MEM) begin
                  ptr <= ptr + 8'h01;
                end
              end else begin
                state <= TEC_IDLE;
              end
            end
          end else if (state == TEC_READ && cnt != 4'h0) begin
            tx            <= {tx[6:0], 1'b0};
            link.d_sda_oe <= ~tx[6];
          end
        end
      end
    end
  end

  // fills the page staging buffer one slot at a time
  always_ff @(posedge clock) begin
    if (state == TEC_DATA && scl_fall && cnt == 4'd8 && !start_ev
        && !stop_ev && cmd == CMD_MEM && !data_first) begin
      stage[ptr[2:0]] <= rx;
    end
  end

  // ------------------------
  // nonvolatile programming
  // ------------------------
  // snapshot on launch so a later restart cannot disturb the commit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prog_busy      <= 1'b0;
      prog_cnt       <= 32'h0;
      commit_mask    <= 8'h00;
      commit_base    <= 5'h00;
      commit_cfg     <= 1'b0;
      commit_cfg_val <= 1'b0;
      one_shot       <= SHOT_RESET;
    end else if (prog_go) begin
      prog_busy      <= 1'b1;
      prog_cnt       <= PROG_CYCLES - 32'd1;
      commit_mask    <= mem_pend ? mask : 8'h00;
      commit_base    <= ptr[7:3];
      commit_cfg     <= cfg_pend;
      commit_cfg_val <= cfg_val;
    end else if (prog_busy) begin
      if (prog_cnt == 32'h0) begin
        prog_busy <= 1'b0;
        if (commit_cfg) begin
          one_shot <= commit_cfg_val;
        end
      end else begin
        prog_cnt <= prog_cnt - 32'd1;
      end
    end
  end

  assign commit_now = prog_busy && prog_cnt == 32'h0;

  // array has no reset: its contents outlive a reset
  always_ff @(posedge clock) begin
    for (int i = 0; i < 8; i++) begin
      if (commit_now && commit_mask[i]) begin
        mem[{commit_base, i[2:0]}] <= stage[i];
      end
    end
  end

  // -----------------------
  // temperature conversion
  // -----------------------
  // halt only clears run, so the conversion under way completes
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run        <= 1'b0;
      converting <= 1'b0;
      done       <= 1'b0;
      conv_cnt   <= 32'h0;
      temp       <= 16'h0000;
    end else begin
      if (conv_go) begin
        run <= 1'b1;
      end else if (conv_halt) begin
        run <= 1'b0;
      end
      if (!converting) begin
        if (run || conv_go) begin
          converting <= 1'b1;
          done       <= 1'b0;
          conv_cnt   <= CONV_CYCLES - 32'd1;
        end
      end else if (conv_cnt == 32'h0) begin
        converting <= 1'b0;
        done       <= 1'b1;
        temp       <= {temp_in[15:4], TEMP_LOW_ZERO};
        if (one_shot && !conv_go) begin
          run <= 1'b0;
        end
      end else begin
        conv_cnt <= conv_cnt - 32'd1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/tec_master.sv
// bus master end: runs byte primitives ordered over axi4-lite
`default_nettype none
module tec_master (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // two-wire link
  tec_link_if.master       link,
  // axi4-lite write channels
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // axi4-lite read channels
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready
);
  import tec_pkg::*;

  logic [3:0]  aw_q;
  logic [31:0] w_q;
  logic        busy;
  logic [1:0]  op;
  logic [1:0]  quarter;
  logic [3:0]  bit_no;
  logic [8:0]  tx;
  logic [8:0]  rx;
  logic [7:0]  div;
  logic        tick;
  logic [1:0]  sda_sync;
  logic        go;

  assign link.scl_o   = 1'b0;
  assign link.m_sda_o = 1'b0;
  assign tick = (div == 8'(TICK_DIV - 1));
  // write fires once both halves are held and no response waits
  assign go = !awready && !wready && !bvalid;

  // ----------------
  // axi4-lite slave
  // ----------------
  // address and data are taken in either order, then one response
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_q    <= 4'h0;
      w_q     <= 32'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OK;
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_q    <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q    <= wdata;
        wready <= 1'b0;
      end
      if (go) begin
        bvalid <= 1'b1;
        bresp  <= (aw_q == OFF_CMD) ? RESP_OK : RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= (araddr == OFF_STATUS || araddr == OFF_CMD)
                   ? RESP_OK : RESP_ERR;
        rdata   <= (araddr == OFF_STATUS)
                   ? {16'h0, rx[8:1], 6'h0, ~rx[0], busy} : 32'h0;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ------------
  // line engine
  // ------------
  // sda is read only after two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sda_sync <= 2'b11;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // four quarters per bit; the divider sets the quarter length
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div           <= 8'h00;
      busy          <= 1'b0;
      op            <= OP_START;
      quarter       <= 2'h0;
      bit_no        <= 4'h0;
      tx            <= 9'h1ff;
      rx            <= 9'h1ff;
      link.scl_oe   <= 1'b0;
      link.m_sda_oe <= 1'b0;
    end else if (!busy) begin
      div <= 8'h00;
      if (go && aw_q == OFF_CMD) begin
        busy    <= 1'b1;
        op      <= w_q[OP_LSB +: 2];
        quarter <= 2'h0;
        bit_no  <= 4'h0;
        tx      <= (w_q[OP_LSB +: 2] == OP_READ)
                   ? {8'hff, ~w_q[ACKOUT_BIT]} : {w_q[7:0], 1'b1};
      end
    end else begin
      div <= tick ? 8'h00 : div + 8'h01;
      if (tick) begin
        quarter <= quarter + 2'h1;
        case (op)
          OP_START: begin
            link.m_sda_oe <= (quarter == 2'h2) || (quarter == 2'h3);
            link.scl_oe   <= (quarter == 2'h3);
            busy          <= (quarter != 2'h3);
          end
          OP_STOP: begin
            link.m_sda_oe <= (quarter == 2'h0);
            link.scl_oe   <= 1'b0;
            busy          <= (quarter != 2'h3);
          end
          default: begin
            // bytes: set data, raise clock, sample, lower clock
            if (quarter == 2'h0) begin
              link.m_sda_oe <= ~tx[8];
            end else if (quarter == 2'h1) begin
              link.scl_oe <= 1'b0;
            end else if (quarter == 2'h2) begin
              rx <= {rx[7:0], sda_sync[1]};
            end else begin
              link.scl_oe <= 1'b1;
              tx          <= {tx[7:0], 1'b1};
              bit_no      <= bit_no + 4'h1;
              busy        <= (bit_no != 4'd8);
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/tec_assertions.sv
// link and status checker for the engine/master pair
`default_nettype none
module tec_assertions #(
  parameter int unsigned PROG_CYCLES = 1000,
  parameter int unsigned CONV_CYCLES = 2000
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // link lines and device drive
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  // device status
  input wire logic prog_busy,
  input wire logic converting
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        scl_q;
  logic        sda_q;
  logic [7:0]  stop_age;
  logic [31:0] prog_cnt;
  logic [31:0] conv_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ------------
  // helper logic
  // ------------
  // line history, so a stop is found without sampled functions
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // cycles since the last stop, saturating so it never wraps
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) stop_age <= 8'hff;
    else if (scl && scl_q && sda && !sda_q) stop_age <= 8'h00;
    else if (stop_age != 8'hff) stop_age <= stop_age + 8'h01;
  end
  // run lengths of programming and conversion
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) prog_cnt <= 32'h0;
    else prog_cnt <= prog_busy ? prog_cnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) conv_cnt <= 32'h0;
    else conv_cnt <= converting ? conv_cnt + 32'h1 : 32'h0;
  end
  // ----------
  // properties
  // ----------
  AST_BUSY_NO_ACK: assert property (
    prog_busy |-> !d_sda_oe) else $error("sda driven while programming");
  AST_PROG_MIN: assert property (
    $fell(prog_busy) |-> $past(prog_cnt) + 2 >= PROG_CYCLES)
    else $error("programming ended early");
  AST_PROG_MAX: assert property (
    prog_cnt <= PROG_CYCLES + 4) else $error("programming overran");
  AST_BUSY_AFTER_STOP: assert property (
    $rose(prog_busy) |-> stop_age <= 8'd12)
    else $error("programming began without a stop");
  AST_BUSY_IDLE_BUS: assert property (
    $rose(prog_busy) |-> scl && sda) else $error("programming mid frame");
  AST_DEV_SCL_LOW: assert property (
    $changed(d_sda_oe) |-> !scl) else $error("device moved sda, scl high");
  AST_DEV_OPEN_DRAIN: assert property (
    d_sda_oe |-> !d_sda_o) else $error("device drove sda high");
  AST_CONV_MIN: assert property (
    $fell(converting) |-> $past(conv_cnt) + 2 >= CONV_CYCLES)
    else $error("conversion cut short");
  // main scenarios reached
  cover property ($rose(prog_busy));
  cover property ($fell(converting));
  cover property ($rose(d_sda_oe));
endmodule
`default_nettype wire

//--- tb/tec_test.sv
// self-checking bench: master and engine joined over the link
`default_nettype none
module tec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tec_pkg::*;
  // short counts keep the run brief
  localparam int unsigned PROG = 1000;
  localparam int unsigned CONV = 2000;
  localparam logic [7:0]  CW   = 8'h9a;  // control, unit 5, write
  localparam logic [7:0]  CR   = 8'h9b;
  logic        clock, nrst, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, conv_q;
  logic        prog_busy, converting;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [1:0]  bresp, rresp;
  logic [15:0] temp_in;
  logic [7:0]  b, b2;
  int          errors = 0, compares = 0, cycles = 0, ends = 0;
  tec_link_if link ();
  tec_device #(.PROG_CYCLES(PROG), .CONV_CYCLES(CONV)) tec_device_inst (
    .clock(clock), .nrst(nrst), .link(link), .unit_select(3'h5),
    .temp_in(temp_in), .prog_busy(prog_busy), .converting(converting));
  tec_master tec_master_inst (
    .clock(clock), .nrst(nrst), .link(link), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  tec_assertions #(.PROG_CYCLES(PROG), .CONV_CYCLES(CONV))
    tec_assertions_inst (.clock(clock), .nrst(nrst), .scl(link.scl),
    .sda(link.sda), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
    .prog_busy(prog_busy), .converting(converting));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // watchdog, and a count of finished conversions
  always @(posedge clock) begin
    conv_q <= converting;
    if (conv_q && !converting) ends <= ends + 1;
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      errors++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------
  // register bus and line primitives
  // ------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask
  // one byte primitive; polls the status busy bit until the master line engine is idle
  task automatic op(input logic [1:0] c, input logic [7:0] d, input logic a);
    axi_wr(OFF_CMD, {21'h0, a, c, d});
    do axi_rd(OFF_STATUS, st);
    while (st[BUSY_BIT] !== 1'b0);
  endtask
  task automatic put(input logic [7:0] d, input logic ea);
    op(OP_WRITE, d, 1'b0);
    chk("ack", st[ACKIN_BIT], ea);
  endtask
  task automatic get(input logic a);
    op(OP_READ, 8'h00, a);
    b = st[15:8];
  endtask
  task automatic wcmd(input logic [7:0] c);
    op(OP_START, 8'h00, 1'b0);
    put(CW, 1'b1);
    put(c, 1'b1);
  endtask
  task automatic rsel();
    op(OP_START, 8'h00, 1'b0);
    put(CR, 1'b1);
  endtask
  task automatic halt();
    op(OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic rd_cfg();
    wcmd(CMD_CFG);
    rsel();
    get(1'b0);
    halt();
  endtask
  task automatic wait_prog();
    chk("prog_busy", prog_busy, 1'b1);
    while (prog_busy) @(posedge clock);
  endtask
  // -----
  // tests
  // -----
  task automatic t_addr();
    logic [7:0] c [4] = '{8'h9a, 8'h98, 8'h1a, 8'hba};
    for (int i = 0; i < 4; i++) begin
      op(OP_START, 8'h00, 1'b0);
      put(c[i], i == 0);
      halt();
    end
    wcmd(8'h55);
    halt();
    repeat (20) @(posedge clock);
    chk("idle", {prog_busy, converting}, 2'b00);
  endtask
  task automatic t_cont();
    int e;
    rd_cfg();
    chk("select", b[6:0], 7'h0a);
    wcmd(CMD_CONV_GO);
    halt();
    e = ends;
    repeat (3 * CONV) @(posedge clock);
    chk("repeat", ends - e > 1, 1'b1);
    wcmd(CMD_CONV_HALT);
    halt();
    repeat (CONV + 10) @(posedge clock);
    e = ends;
    repeat (2 * CONV) @(posedge clock);
    chk("halt", {converting, 15'(ends - e)}, 16'h0);
  endtask
  task automatic t_shot();
    int e;
    wcmd(CMD_CFG);
    put(8'h01, 1'b1);
    halt();
    wait_prog();
    rd_cfg();
    chk("settings", b[6:0], 7'h0b);
    temp_in <= 16'h191f;
    e = ends;
    wcmd(CMD_CONV_GO);
    halt();
    rd_cfg();
    chk("done", b[CFG_DONE_BIT], 1'b0);
    while (converting) @(posedge clock);
    rd_cfg();
    chk("done", b[CFG_DONE_BIT], 1'b1);
    wcmd(CMD_READ_TEMP);
    rsel();
    get(1'b1);
    b2 = b;
    get(1'b0);
    halt();
    chk("temp", {b2, b}, 16'h1910);
    repeat (2 * CONV) @(posedge clock);
    chk("once", 16'(ends - e), 16'h1);
  endtask
  task automatic t_mem();
    logic [7:0] x [9] = '{8'h5a, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
                          8'h17, 8'h18, 8'h11};
    wcmd(CMD_MEM);
    put(8'hff, 1'b1);
    put(8'h5a, 1'b1);
    halt();
    op(OP_START, 8'h00, 1'b0);
    put(CW, 1'b0);
    halt();
    wait_prog();
    wcmd(CMD_MEM);
    put(8'h06, 1'b1);
    for (int i = 0; i < 9; i++) put(8'h10 + i[7:0], 1'b1);
    halt();
    wait_prog();
    wcmd(CMD_MEM);
    put(8'h01, 1'b1);
    put(8'hee, 1'b1);
    op(OP_START, 8'h00, 1'b0);
    halt();
    repeat (20) @(posedge clock);
    chk("abort", prog_busy, 1'b0);
    wcmd(CMD_MEM);
    put(8'hff, 1'b1);
    rsel();
    for (int i = 0; i < 9; i++) begin
      get(i < 8);
      chk("mem", b, x[i]);
    end
    halt();
  endtask
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, temp_in} = 56'h0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    t_addr();
    $display("test addr done");
    t_cont();
    $display("test cont done");
    t_shot();
    $display("test shot done");
    t_mem();
    $display("test mem done");
    close_out();
  end
endmodule
`default_nettype wire
